// file: flash_seq_cfg.svh
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH
// ****************************************************************
// Command codes and frame layout
// ****************************************************************
`define CMD_CMP_BUF2      8'h61
`define CMD_REWRITE_BUF1  8'h58
`define CMD_REWRITE_BUF2  8'h59
`define CMD_CMP_BUF1_DEF  8'h60
`define OPCODE_MSB        31
`define OPCODE_LSB        24
`define PAGE_MSB          17
`define PAGE_LSB          9
`define FRAME_BITS        6'h20
`define FRAME_OVER        6'h21
// ****************************************************************
// Array geometry and status layout
// ****************************************************************
`define PAGE_BYTES        264
`define PAGE_COUNT        512
`define LAST_BYTE         9'h107
`define ERASED_BYTE       8'hff
`define STATUS_READY_BIT  7
`define STATUS_CMP_BIT    6
// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS     20
`define EPD_MS            14
`define CDM_US            400
`define EPD_CYCLES        (`EPD_MS * 1000000 / `CLK_PERIOD_NS)
`define CDM_CYCLES        (`CDM_US * 1000 / `CLK_PERIOD_NS)
`endif

// file: flash_seq_pkg.sv
package flash_seq_pkg;
  // ****************************************************************
  // Sequencer state and register set
  // ****************************************************************
  typedef enum logic [4:0] {
    st_idle  = 5'b00001,
    st_copy  = 5'b00010,
    st_erase = 5'b00100,
    st_prog  = 5'b01000,
    st_cmp   = 5'b10000
  } seq_state_type;

  typedef struct packed {
    seq_state_type st;
    logic          cs_meta;
    logic          cs_sync;
    logic          cs_dly;
    logic [8:0]    idx;
    logic [19:0]   wait_cnt;
    logic          diff;
    logic          rewrite;
    logic          buf_sel;
    logic [8:0]    page;
    logic          ready;
    logic          cmp_flag;
  } seq_type;
endpackage

// file: serial_cmd_shifter.sv
`timescale 1ns/1ps
`include "flash_seq_cfg.svh"
// ****************************************************************
// Link-side command shifter, clocked by the serial clock
// ****************************************************************
module serial_cmd_shifter
  import flash_seq_pkg::*;
(
  input  wire logic        link_clk_in,
  input  wire logic        chip_select_n_in,
  input  wire logic        mosi_in,
  output logic [31:0]      frame_word_out,
  output logic             frame_full_out
);
  logic [5:0]  bits_q;
  logic [5:0]  bits_d;
  logic [31:0] word_q;
  logic        full_q;

  // Bit count saturates past a full frame so an overlong frame is refused.
  always_comb
  begin
    bits_d = bits_q;
    if (bits_q != `FRAME_OVER)
    begin
      bits_d = bits_q + 6'h01;
    end
  end

  // The serial clock stops between frames, so chip select clears the count.
  always_ff @(posedge link_clk_in or posedge chip_select_n_in)
  begin
    if (chip_select_n_in)
    begin
      bits_q <= 6'h00;
    end
    else
    begin
      bits_q <= bits_d;
    end
  end

  // Data is driven on falling edges and sampled here on rising edges, MSB first.
  // The clock may tick once more after select rises, so edges outside a frame are ignored.
  // The full flag is a flop of its own: the count clears the moment select rises,
  // but the sequencer only looks at the flag a few system clocks later.
  always_ff @(posedge link_clk_in)
  begin
    if (!chip_select_n_in)
    begin
      full_q <= (bits_d == `FRAME_BITS);
      if (bits_q < `FRAME_BITS)
      begin
        word_q <= {word_q[30:0], mosi_in};
      end
    end
  end

  // Both stay frozen between frames, because no edge inside a frame arrives.
  assign frame_word_out = word_q;
  assign frame_full_out = full_q;
endmodule // serial_cmd_shifter

// file: flash_page_compare_rewrite.sv
`timescale 1ns/1ps
`include "flash_seq_cfg.svh"
// Behaviour
// - Compare flags mismatch if any bit differs.
// - Select rising starts compare, done within 400us.
// - Status shows busy during compare.
// - Compare result latched into status at end.
// - Page buffers have no defined reset contents.
// - Rewrite codes 0x58 and 0x59 select buffer.
// - Rewrite copies, erases, then programs page back.
// - Status shows busy during rewrite.
// - Single-buffer variant rejects buffer two commands.
// - Only page number bits of address used.
module flash_page_compare_rewrite
  import flash_seq_pkg::*;
#(
  parameter bit          two_buffers                 = 1'b1,
  parameter logic [7:0]  cmp_buf1_code               = `CMD_CMP_BUF1_DEF,
  parameter int unsigned erase_program_cycles        = `EPD_CYCLES,
  parameter int unsigned compare_duration_max_cycles = `CDM_CYCLES
)
(
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       link_clk_in,
  input  wire logic       chip_select_n_in,
  input  wire logic       mosi_in,
  input  wire logic       buf_wr_en_in,
  input  wire logic       buf_wr_sel_in,
  input  wire logic [8:0] buf_wr_addr_in,
  input  wire logic [7:0] buf_wr_data_in,
  output logic [7:0]      status_out
);
  // ****************************************************************
  // Storage and link capture
  // ****************************************************************
  seq_type     q;
  seq_type     d;
  logic [7:0]  flash_mem [`PAGE_COUNT][`PAGE_BYTES];
  logic [7:0]  buf_mem   [2][`PAGE_BYTES];
  logic        page_written_q [`PAGE_COUNT];
  logic [31:0] frame_word;
  logic        frame_full;
  logic [7:0]  flash_rd;
  logic [7:0]  buf_rd;
  logic [7:0]  opcode;
  logic        frame_end;
  logic        mismatch;

  serial_cmd_shifter shifter_u (
    .link_clk_in      (link_clk_in),
    .chip_select_n_in (chip_select_n_in),
    .mosi_in          (mosi_in),
    .frame_word_out   (frame_word),
    .frame_full_out   (frame_full)
  );

  // A never-programmed page reads as erased, so no array reset is needed.
  assign flash_rd  = page_written_q[q.page] ? flash_mem[q.page][q.idx] : `ERASED_BYTE;
  assign buf_rd    = buf_mem[q.buf_sel][q.idx];
  assign mismatch  = (flash_rd != buf_rd);
  assign opcode    = frame_word[`OPCODE_MSB:`OPCODE_LSB];
  // The shifter words are quiet by the time the synced select has risen.
  assign frame_end = q.cs_sync & ~q.cs_dly & frame_full;

  // ****************************************************************
  // Sequencer next state
  // ****************************************************************
  always_comb
  begin
    d         = q;
    d.cs_meta = chip_select_n_in;
    d.cs_sync = q.cs_meta;
    d.cs_dly  = q.cs_sync;
    unique case (q.st)
      st_idle:
      begin
        // Frames arriving while busy are ignored; the host must poll first.
        if (frame_end)
        begin
          d.page = frame_word[`PAGE_MSB:`PAGE_LSB];
          d.idx  = 9'h000;
          d.diff = 1'b0;
          if (opcode == cmp_buf1_code || (two_buffers && opcode == `CMD_CMP_BUF2))
          begin
            d.st      = st_cmp;
            d.buf_sel = (opcode == `CMD_CMP_BUF2);
            d.rewrite = 1'b0;
            d.ready   = 1'b0;
          end
          else if (opcode == `CMD_REWRITE_BUF1 ||
                   (two_buffers && opcode == `CMD_REWRITE_BUF2))
          begin
            d.st      = st_copy;
            d.buf_sel = (opcode == `CMD_REWRITE_BUF2);
            d.rewrite = 1'b1;
            d.ready   = 1'b0;
          end
        end
      end
      st_cmp:
      begin
        d.diff = q.diff | mismatch;
        d.idx  = q.idx + 9'h001;
        if (q.idx == `LAST_BYTE)
        begin
          d.cmp_flag = q.diff | mismatch;
          d.ready    = 1'b1;
          d.st       = st_idle;
        end
      end
      st_copy:
      begin
        d.idx = q.idx + 9'h001;
        if (q.idx == `LAST_BYTE)
        begin
          d.st       = st_erase;
          d.wait_cnt = 20'h00000;
        end
      end
      st_erase:
      begin
        d.wait_cnt = q.wait_cnt + 20'h00001;
        if (q.wait_cnt == 20'(erase_program_cycles - 1))
        begin
          d.st  = st_prog;
          d.idx = 9'h000;
        end
      end
      st_prog:
      begin
        d.idx = q.idx + 9'h001;
        if (q.idx == `LAST_BYTE)
        begin
          d.ready = 1'b1;
          d.st    = st_idle;
        end
      end
    endcase
  end

  // Synchronous reset; the select synchroniser starts at the idle level.
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      q          <= '0;
      q.st       <= st_idle;
      q.cs_meta  <= 1'b1;
      q.cs_sync  <= 1'b1;
      q.cs_dly   <= 1'b1;
      q.ready    <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // ****************************************************************
  // Array and buffer writes
  // ****************************************************************
  // Buffers carry no reset, so their contents stay unknown until written.
  // A page copy takes priority over a user write in the same cycle.
  always_ff @(posedge ref_clk_in)
  begin
    if (buf_wr_en_in && (two_buffers || !buf_wr_sel_in))
    begin
      buf_mem[buf_wr_sel_in][buf_wr_addr_in] <= buf_wr_data_in;
    end
    if (q.st == st_copy)
    begin
      buf_mem[q.buf_sel][q.idx] <= flash_rd;
    end
    if (q.st == st_prog)
    begin
      flash_mem[q.page][q.idx] <= buf_rd;
    end
  end

  // Erase marks the page blank; programming the first byte marks it written.
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < `PAGE_COUNT; i++)
      begin
        page_written_q[i] <= 1'b0;
      end
    end
    else if (q.st == st_erase)
    begin
      page_written_q[q.page] <= 1'b0;
    end
    else if (q.st == st_prog)
    begin
      page_written_q[q.page] <= 1'b1;
    end
  end

  assign status_out = {q.ready, q.cmp_flag, 6'h00};

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [19:0] cmp_cycles_q;

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in || q.st != st_cmp)
    begin
      cmp_cycles_q <= 20'h00000;
    end
    else
    begin
      cmp_cycles_q <= cmp_cycles_q + 20'h00001;
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  cmp_result_a: assert property (
    (q.st == st_cmp && q.idx == `LAST_BYTE) |=>
      status_out[`STATUS_CMP_BIT] == ($past(q.diff) | $past(mismatch)))
    else $error("Compare flag does not match the page and buffer.");
  cmp_start_a: assert property (
    (q.st == st_idle && frame_end && opcode == cmp_buf1_code) |=>
      q.st == st_cmp && !status_out[`STATUS_READY_BIT])
    else $error("Compare did not start at chip select release.");
  cmp_time_a: assert property (
    cmp_cycles_q < 20'(compare_duration_max_cycles))
    else $error("Compare ran past its longest time.");
  cmp_busy_a: assert property (
    (q.st == st_cmp) |-> !status_out[`STATUS_READY_BIT])
    else $error("Ready shown while compare runs.");
  rewrite_busy_a: assert property (
    (q.rewrite && q.st != st_idle) |-> !status_out[`STATUS_READY_BIT])
    else $error("Ready shown while rewrite runs.");
  rewrite_ready_a: assert property (
    (q.rewrite && q.st == st_prog && q.idx == `LAST_BYTE) |=> status_out[`STATUS_READY_BIT])
    else $error("Ready not shown at rewrite end.");
  rewrite_start_a: assert property (
    (q.st == st_idle && frame_end && opcode == `CMD_REWRITE_BUF1) |=>
      q.st == st_copy && !q.buf_sel)
    else $error("Rewrite code did not start a copy into buffer one.");
  rewrite_order_a: assert property (
    (q.st == st_copy && q.idx == `LAST_BYTE) |=> q.st == st_erase ##1 q.st == st_erase)
    else $error("Copy not followed by erase.");
  one_buffer_a: assert property (
    (!two_buffers && q.st == st_idle && frame_end &&
      (opcode == `CMD_CMP_BUF2 || opcode == `CMD_REWRITE_BUF2)) |=> q.st == st_idle)
    else $error("Buffer two command accepted on a single buffer part.");
  page_bits_a: assert property (
    (q.st == st_idle && frame_end) |=>
      q.page == $past(frame_word[`PAGE_MSB:`PAGE_LSB]))
    else $error("Page number not taken from the page field.");

  cmp_done_c:    cover property (q.st == st_cmp ##1 q.st == st_idle);
  cmp_miss_c:    cover property ($rose(status_out[`STATUS_CMP_BIT]));
  rewrite_done_c: cover property (q.st == st_prog ##1 q.st == st_idle);
endmodule // flash_page_compare_rewrite

// file: host_link_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Host side of the serial link
// ****************************************************************
module host_link_model #(
  parameter int half_ns = 24
)
(
  output logic link_clk_out,
  output logic chip_select_n_out,
  output logic mosi_out
);
  // The clock rests high between frames, so select can fall while it is high.
  initial
  begin
    link_clk_out      = 1'b1;
    chip_select_n_out = 1'b1;
    mosi_out          = 1'b0;
  end

  // Sends the top nbits of word; fewer than 32 makes a frame the device must drop.
  task automatic send(input logic [31:0] word, input int nbits);
    int i;
    #(half_ns);
    chip_select_n_out = 1'b0;
    for (i = 0; i < nbits; i++)
    begin
      #(half_ns);
      link_clk_out = 1'b0;
      mosi_out     = (i < 32) ? word[31-i] : 1'b1;
      #(half_ns);
      link_clk_out = 1'b1;
    end
    #(half_ns);
    link_clk_out      = 1'b0;
    chip_select_n_out = 1'b1;
    // The line is released, so it shows the inverse of the last bit, not a stale copy.
    mosi_out          = ~mosi_out;
    #(half_ns);
    link_clk_out = 1'b1;
  endtask
endmodule // host_link_model

// file: flash_page_compare_rewrite_bench.sv
`timescale 1ns/1ps
// ****************************************************************
// Bench for the compare and rewrite sequencer
// ****************************************************************
module flash_page_compare_rewrite_bench;
  import flash_seq_pkg::*;
  logic       ref_clk = 1'b0;
  logic       rst_n   = 1'b0;
  logic       link_clk;
  logic       chip_select_n;
  logic       mosi;
  logic       wr_en   = 1'b0;
  logic       wr_sel  = 1'b0;
  logic [8:0] wr_addr = 9'h000;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] status;
  logic [7:0] status_one;
  logic       one_busy = 1'b0;
  int         num_errors = 0;
  int         n_tests = 0;

  // The system clock runs at 50 MHz.
  always #10 ref_clk = ~ref_clk;

  // Remembers any busy spell of the single-buffer variant.
  always @(negedge ref_clk)
    if (status_one[7] === 1'b0)
      one_busy = 1'b1;

  host_link_model i_host_link_model (
    .link_clk_out      (link_clk),
    .chip_select_n_out (chip_select_n),
    .mosi_out          (mosi)
  );

  flash_page_compare_rewrite #(
    .erase_program_cycles        (20),
    .compare_duration_max_cycles (300)
  ) i_flash_page_compare_rewrite (
    .ref_clk_in (ref_clk), .rst_n_in (rst_n), .link_clk_in (link_clk),
    .chip_select_n_in (chip_select_n), .mosi_in (mosi), .buf_wr_en_in (wr_en),
    .buf_wr_sel_in (wr_sel), .buf_wr_addr_in (wr_addr), .buf_wr_data_in (wr_data),
    .status_out (status)
  );

  // A single-buffer variant shares the link and the buffer port.
  flash_page_compare_rewrite #(
    .two_buffers                 (1'b0),
    .erase_program_cycles        (20),
    .compare_duration_max_cycles (300)
  ) i_flash_page_compare_rewrite_one (
    .ref_clk_in (ref_clk), .rst_n_in (rst_n), .link_clk_in (link_clk),
    .chip_select_n_in (chip_select_n), .mosi_in (mosi), .buf_wr_en_in (wr_en),
    .buf_wr_sel_in (wr_sel), .buf_wr_addr_in (wr_addr), .buf_wr_data_in (wr_data),
    .status_out (status_one)
  );

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  task automatic wr(input logic sel, input logic [8:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    wr_en   = 1'b1;
    wr_sel  = sel;
    wr_addr = a;
    wr_data = d;
    @(negedge ref_clk);
    wr_en = 1'b0;
  endtask

  // Sends a frame, then counts busy cycles; polling ready keeps frames apart.
  task automatic run_cmd(input logic [31:0] w, input int nb, input int busy, input logic [7:0] st);
    int n;
    i_host_link_model.send(w, nb);
    for (n = 0; n < 20 && status[7] !== 1'b0; n++)
      @(negedge ref_clk);
    for (n = 0; n < 2000 && status[7] === 1'b0; n++)
      @(negedge ref_clk);
    check("busy cycles", busy, n);
    check("status", st, status);
  endtask

  // Buffer two all erased; page 1 with offset bits set must match a blank page.
  task automatic t_cmp_match();
    int i;
    for (i = 0; i < 264; i++)
      wr(1'b1, i[8:0], 8'hff);
    run_cmd(32'h6100_03ff, 32, 264, 8'h80);
    check("single buffer busy", 1'b0, one_busy);
    $display("test cmp_match done");
  endtask

  // One bit differs in the last byte; restoring it clears the flag again.
  task automatic t_cmp_mismatch();
    wr(1'b1, 9'h107, 8'h7f);
    run_cmd(32'h6100_0200, 32, 264, 8'hc0);
    wr(1'b1, 9'h107, 8'hff);
    run_cmd(32'h6100_0200, 32, 264, 8'h80);
    $display("test cmp_mismatch done");
  endtask

  // Rewrite must reload the buffer from the page before writing it back.
  task automatic t_rewrite();
    wr(1'b0, 9'h000, 8'h00);
    run_cmd(32'h5800_0600, 32, 548, 8'h80);
    run_cmd(32'h6000_0600, 32, 264, 8'h80);
    wr(1'b1, 9'h005, 8'h12);
    one_busy = 1'b0;
    run_cmd(32'h5900_0800, 32, 548, 8'h80);
    check("single buffer rewrite two", 1'b0, one_busy);
    run_cmd(32'h6100_0800, 32, 264, 8'h80);
    wr(1'b1, 9'h005, 8'h12);
    run_cmd(32'h6100_0800, 32, 264, 8'hc0);
    $display("test rewrite done");
  endtask

  // Short and overlong frames and unknown codes leave the device idle.
  task automatic t_refused();
    run_cmd(32'h6100_0200, 31, 0, 8'h80);
    run_cmd(32'h6100_0200, 33, 0, 8'h80);
    run_cmd(32'h7700_0200, 32, 0, 8'h80);
    $display("test refused done");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // The tests need under 10000 cycles; the watchdog allows three times that.
  initial
  begin
    #(20 * 30000);
    num_errors++;
    conclude();
  end

  initial
  begin
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    check("reset status", 8'h80, status);
    check("reset status one", 8'h80, status_one);
    t_cmp_match();
    t_cmp_mismatch();
    t_refused();
    t_rewrite();
    conclude();
  end
endmodule // flash_page_compare_rewrite_bench
